// File: design/atrf_framer.sv
// Local command response framer: turns one answered command into a
// byte-serial response frame for the host link.
// Assumes the command engine presents one request at a time with its
// returned value bytes pushed through the data port, all on one clock.
`timescale 1ns/10ps

module atrf_framer (
  input  wire logic        clock,
  input  wire logic        rstn,
  // Answer request from the command engine.
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_tag,
  input  wire logic [15:0] req_cmd,
  input  wire logic [7:0]  req_status,
  input  wire logic        req_query,
  input  wire logic [7:0]  req_data_len,
  // Configured value bytes for a query answer.
  input  wire logic        data_valid,
  output logic             data_ready,
  input  wire logic [7:0]  data_byte,
  // Link configuration.
  input  wire logic [7:0]  escape_setting,
  // Byte stream towards the host.
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_byte,
  output logic             tx_last,
  output logic             busy
);
  import atrf_pkg::*;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------

  // True for the byte values that the escaped link must not carry bare.
  function automatic logic atrf_needs_escape(input logic [7:0] b);
    atrf_needs_escape = (b == DELIM_BYTE) || (b == ESC_MARK) ||
                        (b == XON_BYTE)   || (b == XOFF_BYTE);
  endfunction

  // -----------------------------------------------------------------
  // Value FIFO
  // -----------------------------------------------------------------

  // Two stream carriers: one into the FIFO and one out of it.
  atrf_stream_if #(.W(BYTE_W)) val_in ();
  atrf_stream_if #(.W(BYTE_W)) val_out ();

  // The FIFO decouples the value source from link back-pressure.
  assign val_in.valid = data_valid;
  assign val_in.data  = data_byte;
  assign data_ready   = val_in.ready;

  // Four bytes of slack let the engine run ahead of the link.
  atrf_fifo #(
    .W     (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .rstn  (rstn),
    .in_s  (val_in),
    .out_s (val_out)
  );

  // -----------------------------------------------------------------
  // Framer state
  // -----------------------------------------------------------------

  // Register copy, its next value and the per-cycle byte decisions.
  atrf_regs_t  r;
  atrf_regs_t  next_r;
  logic        can;
  logic        send;
  logic        add;
  logic        raw;
  logic        last;
  logic        pop;
  logic [7:0]  b;
  logic [7:0]  n_left;

  // Ports are driven straight from the state register.
  assign req_ready     = r.req_ready;
  assign tx_valid      = r.tx_valid;
  assign tx_byte       = r.tx_byte;
  assign tx_last       = r.tx_last;
  assign busy          = r.busy;
  assign val_out.ready = pop;

  // Frame order on the link: delimiter, length high and low, type,
  // tag, two command characters, status, the value bytes of a query,
  // and the checksum. The length counts from the type byte through the
  // last value byte. A suppressed answer still drains its value bytes
  // so that the next query finds its own bytes at the head of the FIFO.

  // Next-state logic: one byte is offered per free output slot.
  always_comb begin
    next_r = r;
    send   = 1'b0;
    add    = 1'b0;
    raw    = 1'b0;
    last   = 1'b0;
    pop    = 1'b0;
    b      = '0;
    n_left = req_query ? req_data_len : 8'h00;

    // A byte taken by the host frees the output slot.
    if (r.tx_valid && tx_ready) begin
      next_r.tx_valid = 1'b0;
      next_r.tx_last  = 1'b0;
    end
    can = !r.tx_valid || tx_ready;

    case (r.state)
      // Wait for a request and latch everything the frame needs.
      ST_IDLE: begin
        // New answers are taken straight after the last one.
        if (req_valid && r.req_ready) begin
          next_r.tag    = req_tag;
          next_r.cmd    = req_cmd;
          next_r.status = req_status;
          next_r.left   = n_left;
          next_r.length = HDR_LEN + {8'h00, n_left};
          next_r.sum    = '0;
          next_r.esc_on = escape_setting == ESC_ESCAPED;
          if (req_tag == 8'h00) begin
            // Zero tag: no frame, but value bytes are still drained.
            next_r.state = (n_left != 8'h00) ? ST_SKIP : ST_IDLE;
          end else begin
            next_r.state = ST_DELIM;
          end
        end
      end

      // Start of frame; this byte is never escaped.
      ST_DELIM: begin
        send = can && !r.esc_pend;
        raw  = 1'b1;
        b    = DELIM_BYTE;
        if (send) begin
          next_r.state = ST_LEN_HI;
        end
      end

      // Upper length byte, nonzero only when a query carries more than 250 value bytes.
      ST_LEN_HI: begin
        send = can && !r.esc_pend;
        b    = r.length[15:8];
        if (send) begin
          next_r.state = ST_LEN_LO;
        end
      end

      // Lower length byte; the sum starts only after it.
      ST_LEN_LO: begin
        send = can && !r.esc_pend;
        b    = r.length[7:0];
        if (send) begin
          next_r.state = ST_TYPE;
        end
      end

      // Fixed answer type, first byte counted in the checksum.
      ST_TYPE: begin
        send = can && !r.esc_pend;
        add  = 1'b1;
        b    = TYPE_ANSWER;
        if (send) begin
          next_r.state = ST_TAG;
        end
      end

      // Echoed tag so the host can pair answer and request.
      ST_TAG: begin
        send = can && !r.esc_pend;
        add  = 1'b1;
        b    = r.tag;
        if (send) begin
          next_r.state = ST_CMD_HI;
        end
      end

      // First command character.
      ST_CMD_HI: begin
        send = can && !r.esc_pend;
        add  = 1'b1;
        b    = r.cmd[15:8];
        if (send) begin
          next_r.state = ST_CMD_LO;
        end
      end

      // Second command character.
      ST_CMD_LO: begin
        send = can && !r.esc_pend;
        add  = 1'b1;
        b    = r.cmd[7:0];
        if (send) begin
          next_r.state = ST_STATUS;
        end
      end

      // Outcome code, passed through without a range check.
      ST_STATUS: begin
        send = can && !r.esc_pend;
        add  = 1'b1;
        b    = r.status;
        if (send) begin
          // A change answer goes straight to the checksum.
          next_r.state = (r.left != 8'h00) ? ST_DATA : ST_CSUM;
        end
      end

      // Value bytes of a query, counted down to zero.
      ST_DATA: begin
        // Value bytes wait for the FIFO as well as the link.
        send = can && !r.esc_pend && val_out.valid;
        pop  = send;
        add  = 1'b1;
        b    = val_out.data;
        if (send) begin
          next_r.left = r.left - 8'h01;
          if (r.left == 8'h01) begin
            next_r.state = ST_CSUM;
          end
        end
      end

      // Closing checksum, the only byte marked as last.
      ST_CSUM: begin
        send = can && !r.esc_pend;
        last = 1'b1;
        b    = CSUM_BASE - r.sum;
        if (send) begin
          next_r.state = ST_IDLE;
        end
      end

      // No frame goes out while these bytes are dropped.
      ST_SKIP: begin
        // Suppressed answer: discard its value bytes quietly.
        pop = val_out.valid;
        if (pop) begin
          next_r.left = r.left - 8'h01;
          if (r.left == 8'h01) begin
            next_r.state = ST_IDLE;
          end
        end
      end

      // Unused codes fall back to idle.
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // Second half of an escaped pair goes out before anything new.
    // Every state holds back while a pair is half sent, so no new byte
    // can overtake the flipped byte that still waits here.
    if (can && r.esc_pend) begin
      next_r.tx_valid = 1'b1;
      next_r.tx_byte  = r.esc_byte;
      next_r.tx_last  = r.esc_last;
      next_r.esc_pend = 1'b0;
    end

    // Load the chosen byte, escaping it when the link asks for that.
    // The sum runs over the plain byte, never over the escape mark.
    if (send) begin
      if (add) begin
        next_r.sum = r.sum + b;
      end
      next_r.tx_valid = 1'b1;
      if (r.esc_on && !raw && atrf_needs_escape(b)) begin
        next_r.tx_byte  = ESC_MARK;
        next_r.tx_last  = 1'b0;
        next_r.esc_pend = 1'b1;
        next_r.esc_byte = b ^ ESC_FLIP;
        next_r.esc_last = last;
      end else begin
        next_r.tx_byte = b;
        next_r.tx_last = last;
      end
    end

    // Status flags are registered so the ports come from flip-flops.
    // Both look at the next state, so they agree with it on every edge.
    next_r.req_ready = next_r.state == ST_IDLE;
    next_r.busy      = (next_r.state != ST_IDLE) || next_r.tx_valid ||
                       next_r.esc_pend;
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------

  // Whole framer state is held in one register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

endmodule

// File: design/atrf_pkg.sv
// Constants, types and reset values of the command response framer.
// Assumes one 50 MHz clock and an active-low asynchronous reset.

package atrf_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int        BYTE_W       = 8;
  localparam int        FIFO_DEPTH   = 4;
  localparam logic [7:0] DELIM_BYTE  = 8'h7e;
  localparam logic [7:0] TYPE_ANSWER = 8'h88;
  localparam logic [7:0] TYPE_REQ    = 8'h08;
  localparam logic [7:0] TYPE_QREQ   = 8'h09;
  localparam logic [7:0] CSUM_BASE   = 8'hff;
  localparam logic [15:0] HDR_LEN    = 16'h0005;
  localparam int        OFS_DELIM    = 0;
  localparam int        OFS_LENGTH   = 1;
  localparam int        OFS_TYPE     = 3;
  localparam int        OFS_TAG      = 4;
  localparam int        OFS_CMD      = 5;
  localparam int        OFS_STATUS   = 7;
  localparam int        OFS_DATA     = 8;

  // ---------------------------------------------------------------
  // Outcome codes and escape settings
  // ---------------------------------------------------------------
  localparam logic [7:0] STAT_OK      = 8'h00;
  localparam logic [7:0] STAT_ERROR   = 8'h01;
  localparam logic [7:0] STAT_BAD_CMD = 8'h02;
  localparam logic [7:0] STAT_BAD_PAR = 8'h03;
  localparam logic [7:0] ESC_NONE     = 8'h01;
  localparam logic [7:0] ESC_ESCAPED  = 8'h02;
  localparam logic [7:0] ESC_MARK     = 8'h7d;
  localparam logic [7:0] ESC_FLIP     = 8'h20;
  localparam logic [7:0] XON_BYTE     = 8'h11;
  localparam logic [7:0] XOFF_BYTE    = 8'h13;

  // ---------------------------------------------------------------
  // Framer states, Gray coded along the byte order
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_DELIM  = 4'h1,
    ST_LEN_HI = 4'h3,
    ST_LEN_LO = 4'h2,
    ST_TYPE   = 4'h6,
    ST_TAG    = 4'h7,
    ST_CMD_HI = 4'h5,
    ST_CMD_LO = 4'h4,
    ST_STATUS = 4'hc,
    ST_DATA   = 4'hd,
    ST_CSUM   = 4'hf,
    ST_SKIP   = 4'he
  } atrf_state_t;

  typedef struct packed {
    atrf_state_t state;
    logic        req_ready;
    logic        busy;
    logic        tx_valid;
    logic [7:0]  tx_byte;
    logic        tx_last;
    logic        esc_on;
    logic        esc_pend;
    logic [7:0]  esc_byte;
    logic        esc_last;
    logic [7:0]  tag;
    logic [15:0] cmd;
    logic [7:0]  status;
    logic [7:0]  left;
    logic [15:0] length;
    logic [7:0]  sum;
  } atrf_regs_t;

  localparam atrf_regs_t REGS_RST = '{
    state     : ST_IDLE,
    req_ready : 1'b1,
    default   : '0
  };

endpackage

// File: design/atrf_stream_if.sv
// Byte stream carrier between the framer and its data FIFO.
// Assumes source and sink run on the same clock.
`timescale 1ns/10ps

interface atrf_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: design/atrf_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two and both sides share one clock.
`timescale 1ns/10ps

module atrf_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic  clock,
  input  wire logic  rstn,
  atrf_stream_if.snk in_s,
  atrf_stream_if.src out_s
);
  import atrf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
    logic                    in_rdy;
    logic                    out_vld;
  } atrf_fifo_regs_t;

  atrf_fifo_regs_t r;
  atrf_fifo_regs_t next_r;
  logic            push;
  logic            pop;

  // Ready and valid come from flags so both sides see clean levels.
  assign in_s.ready  = r.in_rdy;
  assign out_s.valid = r.out_vld;
  assign out_s.data  = r.mem[r.rd];

  // Pointer, count and flag update.
  always_comb begin
    next_r = r;
    push   = in_s.valid && r.in_rdy;
    pop    = r.out_vld && out_s.ready;
    if (push) begin
      next_r.mem[r.wr] = in_s.data;
      next_r.wr        = r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = r.rd + 1'b1;
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    next_r.in_rdy  = next_r.cnt != FULL_CNT;
    next_r.out_vld = next_r.cnt != '0;
  end

  // State register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r <= '{in_rdy: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

endmodule

// File: sim/atrf_framer_assertions.sv
// Concurrent checks on the ports of the command response framer.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps

module atrf_framer_chk (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_tag,
  input wire logic [15:0] req_cmd,
  input wire logic [7:0]  req_status,
  input wire logic        req_query,
  input wire logic [7:0]  req_data_len,
  input wire logic [7:0]  escape_setting,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_last,
  input wire logic        busy
);
  import atrf_pkg::*;
  typedef struct packed {
    logic        esc;
    logic [15:0] len;
    logic [7:0]  tag;
    logic [15:0] cmd;
    logic [7:0]  st;
  } atrf_chk_req_t;
  atrf_chk_req_t pend;
  atrf_chk_req_t cur;
  logic [7:0]    idx;

  // Note a request when taken; adopt it once its delimiter has left,
  // since the next request may be taken while a checksum still waits.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend <= '0;
      cur  <= '0;
      idx  <= '0;
    end else begin
      if (req_valid && req_ready && req_tag != 8'h00)
        pend <= '{escape_setting == ESC_ESCAPED,
                  HDR_LEN + (req_query ? 16'(req_data_len) : 16'h0000),
                  req_tag, req_cmd, req_status};
      if (tx_valid && tx_ready) begin
        idx <= tx_last ? 8'h00 : idx + 8'h01;
        if (idx == 8'h00)
          cur <= pend;
      end
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_live_take;
    req_valid && req_ready && req_tag != 8'h00;
  endsequence
  sequence s_frame_opens;
    !req_ready ##1 (!req_ready && busy && tx_valid);
  endsequence

  a_open_delim: assert property (
    tx_valid && idx == 8'h00 |-> tx_byte == DELIM_BYTE)
    else $error("frame does not open with the delimiter");
  a_length_field: assert property (
    tx_valid && (idx == 8'h01 || idx == 8'h02) |->
    tx_byte == (idx == 8'h01 ? cur.len[15:8] : cur.len[7:0]))
    else $error("length field wrong");
  a_type_code: assert property (
    tx_valid && idx == 8'h03 |-> tx_byte == TYPE_ANSWER)
    else $error("type byte wrong");
  a_tag_echo: assert property (
    tx_valid && idx == 8'h04 |-> tx_byte == cur.tag)
    else $error("tag not echoed");
  a_cmd_chars: assert property (
    tx_valid && (idx == 8'h05 || idx == 8'h06) |->
    tx_byte == (idx == 8'h05 ? cur.cmd[15:8] : cur.cmd[7:0]))
    else $error("command characters wrong");
  a_status_code: assert property (
    tx_valid && idx == 8'h07 |-> tx_byte == cur.st)
    else $error("status byte wrong");
  a_last_place: assert property (
    tx_valid && tx_last && !cur.esc |-> idx == cur.len[7:0] + 8'h03)
    else $error("final byte at wrong offset");
  a_silent_tag: assert property (
    req_valid && req_ready && req_tag == 8'h00 && !req_query |=> req_ready)
    else $error("zero tag started a frame");
  a_take_busy: assert property (
    s_live_take |=> s_frame_opens)
    else $error("taken request did not open a frame");
  a_hold_byte: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
    else $error("offered byte changed before taken");
endmodule

bind atrf_framer atrf_framer_chk u_chk (.clock(clock), .rstn(rstn),
  .req_valid(req_valid), .req_ready(req_ready), .req_tag(req_tag),
  .req_cmd(req_cmd), .req_status(req_status), .req_query(req_query),
  .req_data_len(req_data_len), .escape_setting(escape_setting),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
  .tx_last(tx_last), .busy(busy));

// File: sim/atrf_host_model.sv
// Host receiver on the framer's byte stream, with optional stalls.
// Assumes the bench tells it whether escaping is in use.
`timescale 1ns/10ps

module atrf_host_model (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_last,
  input  wire logic       esc_on,
  input  wire logic       stall_on,
  output logic            tx_ready,
  output logic            rx_stb,
  output logic [7:0]      rx_byte,
  output logic            rx_last,
  output logic [7:0]      rx_sum
);
  import atrf_pkg::*;
  logic [7:0] cnt;
  logic       unesc;
  logic       take;
  assign take = tx_valid && tx_ready;

  // Take bytes, undo escapes and sum from the type byte onward.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      rx_stb   <= 1'b0;
      rx_byte  <= 8'h00;
      rx_last  <= 1'b0;
      rx_sum   <= 8'h00;
      cnt      <= 8'h00;
      unesc    <= 1'b0;
    end else begin
      tx_ready <= stall_on ? ($urandom % 4 != 0) : 1'b1;
      rx_stb   <= take;
      rx_byte  <= tx_byte;
      rx_last  <= tx_last;
      if (take && esc_on && cnt != 8'h00 && !unesc && tx_byte == ESC_MARK)
        unesc <= 1'b1;
      else if (take) begin
        unesc <= 1'b0;
        cnt   <= tx_last ? 8'h00 : cnt + 8'h01;
        if (cnt == 8'h00)
          rx_sum <= 8'h00;
        else if (cnt >= 8'h03)
          rx_sum <= rx_sum + (unesc ? tx_byte ^ ESC_FLIP : tx_byte);
      end
    end
  end
endmodule

// File: sim/atrf_framer_tb_top.sv
// Self-checking bench for the command response framer.
// Assumes the framer, its FIFO, the host model and the bound checker.
`timescale 1ns/10ps

module atrf_framer_tb_top;
  import atrf_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_query = 1'b0;
  logic data_valid = 1'b0, stall_on = 1'b0;
  logic [7:0] req_tag = 8'h00, req_status = 8'h00, req_data_len = 8'h00;
  logic [7:0] data_byte = 8'h00, escape_setting = ESC_NONE;
  logic [15:0] req_cmd = 16'h0000;
  logic req_ready, data_ready, tx_valid, tx_ready, tx_last, busy;
  logic rx_stb, rx_last;
  logic [7:0] tx_byte, rx_byte, rx_sum;
  logic [7:0] expq[$];
  logic [7:0] dq[$];
  int errors = 0, n_tests = 0;

  always #10 clock = ~clock;

  atrf_framer dut (.clock(clock), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req_tag(req_tag), .req_cmd(req_cmd),
    .req_status(req_status), .req_query(req_query),
    .req_data_len(req_data_len), .data_valid(data_valid),
    .data_ready(data_ready), .data_byte(data_byte),
    .escape_setting(escape_setting), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_last(tx_last),
    .busy(busy));
  atrf_host_model u_host (.clock(clock), .rstn(rstn), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_last(tx_last),
    .esc_on(escape_setting == ESC_ESCAPED), .stall_on(stall_on),
    .tx_ready(tx_ready), .rx_stb(rx_stb), .rx_byte(rx_byte),
    .rx_last(rx_last), .rx_sum(rx_sum));

  // ---------------------------------------------------------------
  // Comparison, verdict and expected frame building
  // ---------------------------------------------------------------
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Notes one byte, escaped after the delimiter when escaping is on.
  function automatic void note(logic [7:0] b);
    if (escape_setting == ESC_ESCAPED && (b == DELIM_BYTE ||
        b == ESC_MARK || b == XON_BYTE || b == XOFF_BYTE)) begin
      expq.push_back(ESC_MARK);
      expq.push_back(b ^ ESC_FLIP);
    end else
      expq.push_back(b);
  endfunction

  task automatic push(logic [7:0] b);
    int k;
    data_valid <= 1'b1;
    data_byte  <= b;
    dq.push_back(b);
    for (k = 0; k < 300; k++) begin
      @(posedge clock);
      if (data_ready === 1'b1) break;
    end
    if (k == 300) begin
      errors++;
      conclude();
    end
  endtask

  // Each call stands for a 0x08 or 0x09 request from the host.
  task automatic send(logic [7:0] tag, logic [15:0] cmd, logic [7:0] st,
                      logic q, logic [7:0] n);
    logic [7:0] f[$];
    logic [7:0] sum;
    int         k;
    // Value bytes are pushed before the request; stop offering the last.
    data_valid <= 1'b0;
    req_valid <= 1'b1;
    req_tag <= tag;
    req_cmd <= cmd;
    req_status <= st;
    req_query <= q;
    req_data_len <= n;
    f = {TYPE_ANSWER, tag, cmd[15:8], cmd[7:0], st};
    if (q) repeat (n) f.push_back(dq.pop_front());
    sum = 8'h00;
    foreach (f[i]) sum += f[i];
    f.push_back(CSUM_BASE - sum);
    if (tag != 8'h00) begin
      expq.push_back(DELIM_BYTE);
      note(8'h00);
      note(8'(f.size() - 1));
      foreach (f[i]) note(f[i]);
    end
    for (k = 0; k < 300; k++) begin
      @(posedge clock);
      if (req_ready === 1'b1) break;
    end
    if (k == 300) begin
      errors++;
      conclude();
    end
  endtask

  task automatic idle_drain;
    int k;
    req_valid  <= 1'b0;
    data_valid <= 1'b0;
    for (k = 0; k < 2000; k++) begin
      @(posedge clock);
      if (expq.size() == 0 && busy === 1'b0) break;
    end
    if (k == 2000) begin
      errors++;
      conclude();
    end
  endtask

  // Takes the oldest noted byte whenever the host reports one.
  always @(posedge clock) begin
    if (rx_stb === 1'b1) begin
      if (expq.size() == 0) check("extra_byte", rx_byte, 8'hxx);
      else check("tx_byte", rx_byte, expq.pop_front());
      if (rx_last === 1'b1) check("frame_sum", rx_sum, CSUM_BASE);
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(68));
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    send(8'h01, 16'h4e49, STAT_OK, 1'b0, 8'h00);
    idle_drain();
    push(8'hff);
    push(8'hfe);
    send(8'h17, 16'h5450, STAT_OK, 1'b1, 8'h02);
    idle_drain();
    stall_on <= 1'b1;
    for (int s = 0; s < 4; s++)
      send(8'($urandom_range(255, 1)), 16'($urandom), 8'(s), 1'b0,
           8'h00);
    idle_drain();
    push(8'haa);
    push(8'hbb);
    send(8'h00, 16'h4e44, STAT_OK, 1'b1, 8'h02);
    send(8'h00, 16'h4e44, STAT_OK, 1'b0, 8'h00);
    send(8'h2a, 16'h4e44, STAT_OK, 1'b0, 8'h00);
    idle_drain();
    escape_setting <= ESC_ESCAPED;
    push(8'h7e);
    push(8'h7d);
    push(8'h11);
    push(8'h13);
    data_valid <= 1'b0;
    repeat (3) @(posedge clock);
    check("data_ready", {7'h00, data_ready}, 8'h00);
    send(8'h05, 16'h5450, STAT_BAD_CMD, 1'b1, 8'h04);
    idle_drain();
    escape_setting <= ESC_NONE;
    push(8'h7e);
    send(8'h33, 16'h4e49, STAT_BAD_PAR, 1'b1, 8'h01);
    idle_drain();
    conclude();
  end
endmodule
